// [core/hwmcr_cfg.svh]
// Offsets, field positions, reset values and timing counts of the monitor.
`ifndef HWMCR_CFG_SVH
`define HWMCR_CFG_SVH

// Register indices; the Wishbone byte address is four times the index.
`define HWM_IDX_RUN 8'h01
`define HWM_IDX_MODE 8'h02
`define HWM_IDX_CASE 8'h03
`define HWM_IDX_CPU 8'h0a
`define HWM_IDX_EN 8'h30
`define HWM_IDX_BHI 8'h60
`define HWM_IDX_BLO 8'h61
`define HWM_IDX_ISEL 8'h70
`define HWM_IDX_ISTS 8'h80
`define HWM_IDX_ICLR 8'h81
`define HWM_IDX_IEN 8'h82

// Field positions.
`define HWM_RUN_PD 2
`define HWM_RUN_FAN 1
`define HWM_RUN_VT 0
`define HWM_MODE_TONE 6
`define HWM_MODE_HEAT 4
`define HWM_MODE_PME 2
`define HWM_MODE_ALERT 0
`define HWM_CPU_IIR 5
`define HWM_CPU_VTT 2
`define HWM_CPU_METH 0

// Reset values.
`define HWM_RST_RUN 3'h0
`define HWM_RST_MODE 8'h00
`define HWM_RST_CPU 6'h00
`define HWM_RST_EN 1'b1
`define HWM_RST_BHI 8'h02
`define HWM_RST_BLO 8'h95
`define HWM_RST_ISEL 4'h0

// Timing: clock rate, blink half period and tone half periods.
`define HWM_CLK_KHZ 20000
`define HWM_BLINK_HALF_MS 500
`define HWM_TONE800_HALF_US 625
`define HWM_TONE400_HALF_US 1250
`define HWM_BLINK_HALF_CYC (`HWM_BLINK_HALF_MS * `HWM_CLK_KHZ)
`define HWM_T800_CYC (`HWM_TONE800_HALF_US * `HWM_CLK_KHZ / 1000)
`define HWM_T400_CYC (`HWM_TONE400_HALF_US * `HWM_CLK_KHZ / 1000)

`endif

// [core/hwmcr_pkg.sv]
// Types shared by the hardware monitor configuration register bank.
package hwmcr_pkg;

    // Output mode of the overheat and alert pins.
    typedef enum logic [1:0] {
        HWMCR_LOW = 2'b00,
        HWMCR_HIGH = 2'b01,
        HWMCR_LED = 2'b10,
        HWMCR_BEEP = 2'b11
    } hwmcr_mode_t;

    // Configuration levels handed to the monitor core.
    typedef struct packed {
        logic monitor_unit_enable;
        logic power_down;
        logic fan_run;
        logic vt_run;
        logic [15:0] io_base;
        logic [3:0] monitor_irq_select;
        logic cpu_reading_smoothing_enable;
        logic [1:0] vtt_select;
        logic [1:0] cpu_temp_method_select;
    } hwmcr_ctrl_t;

    // Whole state of the register bank.
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [2:0] sy1;
        logic [2:0] sy2;
        logic [2:0] prev;
        logic [2:0] run;
        logic [7:0] mode;
        logic flag;
        logic [5:0] cpu;
        logic en;
        logic [7:0] bhi;
        logic [7:0] blo;
        logic [3:0] isel;
        logic [2:0] ists;
        logic [2:0] ien;
        logic [23:0] bcnt;
        logic blink;
        logic [14:0] tcnt;
        logic tone;
        logic heat;
        logic alrt;
        logic beep;
        logic pme;
        logic irq;
    } hwmcr_state_t;

endpackage : hwmcr_pkg

// [core/hwmcr_regs.sv]
// Hardware monitor configuration and control registers on classic Wishbone.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`include "hwmcr_cfg.svh"

module hwmcr_regs
    import hwmcr_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = `HWM_BLINK_HALF_CYC,
    parameter int unsigned T800_CYC = `HWM_T800_CYC,
    parameter int unsigned T400_CYC = `HWM_T400_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Event pins from outside the clock domain.
    input wire logic intrusion_i,
    input wire logic overheat_event_i,
    input wire logic alert_event_i,
    // Pins and configuration levels.
    output logic overheat_output_o,
    output logic alert_output_o,
    output logic beep_o,
    output logic pme_o,
    output logic irq_o,
    output hwmcr_ctrl_t ctrl_o
);

    hwmcr_state_t s;
    hwmcr_state_t next_s;
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [2:0] ev;
    logic [7:0] rd;

    // Pin drive for one of the four output modes.
    function automatic logic pin_drive(input logic [1:0] m,
                                       input logic act,
                                       input logic blk,
                                       input logic tn);
        logic r;
        r = act;
        case (hwmcr_mode_t'(m))
            HWMCR_LOW: r = ~act;
            HWMCR_HIGH: r = act;
            HWMCR_LED: r = act & blk;
            HWMCR_BEEP: r = act & tn;
            default: r = act;
        endcase
        return r;
    endfunction : pin_drive

    // Request decode; index is the word address.
    assign req = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign wd = wb_dat_i[7:0];
    // Events are rising edges of the synchronised pins.
    assign ev = s.sy2 & ~s.prev;

    // Read multiplexer; unmapped indices read as zero.
    always_comb begin
        rd = 8'h00;
        case (idx)
            `HWM_IDX_RUN: rd = {5'h00, s.run};
            `HWM_IDX_MODE: rd = s.mode;
            `HWM_IDX_CASE: rd = {7'h00, s.flag};
            `HWM_IDX_CPU: rd = {2'h0, s.cpu};
            `HWM_IDX_EN: rd = {7'h00, s.en};
            `HWM_IDX_BHI: rd = s.bhi;
            `HWM_IDX_BLO: rd = s.blo;
            `HWM_IDX_ISEL: rd = {4'h0, s.isel};
            `HWM_IDX_ISTS: rd = {5'h00, s.ists};
            `HWM_IDX_IEN: rd = {5'h00, s.ien};
            default: rd = 8'h00;
        endcase
    end

    // Next state of the whole bank.
    always_comb begin
        next_s = s;
        // Bus answers one cycle after the request is taken.
        next_s.ack = req;
        if (req) begin
            next_s.rdat = {24'h000000, rd};
        end
        // Two flip-flops before any logic reads the pins.
        next_s.sy1 = {alert_event_i, overheat_event_i, intrusion_i};
        next_s.sy2 = s.sy1;
        next_s.prev = s.sy2;
        // Register writes; only byte lane 0 carries data.
        if (wr) begin
            case (idx)
                `HWM_IDX_RUN: next_s.run = wd[2:0];
                `HWM_IDX_MODE: next_s.mode = wd;
                `HWM_IDX_CPU: next_s.cpu = wd[5:0];
                `HWM_IDX_EN: next_s.en = wd[0];
                `HWM_IDX_BHI: next_s.bhi = wd;
                `HWM_IDX_BLO: next_s.blo = wd;
                `HWM_IDX_ISEL: next_s.isel = wd[3:0];
                `HWM_IDX_IEN: next_s.ien = wd[2:0];
                default: next_s.run = next_s.run;
            endcase
        end
        if (wr && idx == `HWM_IDX_CASE && wd[0]) begin
            next_s.flag = 1'b0;
        end
        if (s.sy2[0]) begin
            next_s.flag = 1'b1;
        end
        // Sticky interrupt status; an event in the clear cycle survives.
        if (wr && idx == `HWM_IDX_ICLR) begin
            next_s.ists = s.ists & ~wd[2:0];
        end
        next_s.ists = next_s.ists | ev;
        next_s.irq = |(next_s.ists & next_s.ien);
        if (s.bcnt == 24'(BLINK_HALF_CYC - 1)) begin
            next_s.bcnt = 24'h000000;
            next_s.blink = ~s.blink;
        end else begin
            next_s.bcnt = s.bcnt + 24'h000001;
        end
        // tone alternates 800/400 each blink half.
        if (s.tcnt == 15'(T400_CYC - 1) ||
            (!s.blink && s.tcnt >= 15'(T800_CYC - 1))) begin
            next_s.tcnt = 15'h0000;
            next_s.tone = ~s.tone;
        end else begin
            next_s.tcnt = s.tcnt + 15'h0001;
        end
        next_s.heat = pin_drive(s.mode[`HWM_MODE_HEAT +: 2], s.sy2[1],
                               s.blink, s.tone);
        next_s.alrt = pin_drive(s.mode[`HWM_MODE_ALERT +: 2], s.sy2[2],
                                s.blink, s.tone);
        next_s.beep = s.flag & s.mode[`HWM_MODE_TONE] & s.tone;
        next_s.pme = s.flag & s.mode[`HWM_MODE_PME];
    end

    // State register; synchronous reset to documented defaults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.run <= `HWM_RST_RUN;
            s.mode <= `HWM_RST_MODE;
            s.cpu <= `HWM_RST_CPU;
            s.en <= `HWM_RST_EN;
            s.bhi <= `HWM_RST_BHI;
            s.blo <= `HWM_RST_BLO;
            s.isel <= `HWM_RST_ISEL;
            // Idle low pin mode is active low, so the pin idles high.
            s.heat <= 1'b1;
            s.alrt <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Bus and pin outputs come straight from flip-flops.
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign overheat_output_o = s.heat;
    assign alert_output_o = s.alrt;
    assign beep_o = s.beep;
    assign pme_o = s.pme;
    assign irq_o = s.irq;

    // Configuration levels; power down and disable override the starts.
    always_comb begin
        ctrl_o.monitor_unit_enable = s.en;
        ctrl_o.power_down = s.run[`HWM_RUN_PD] | ~s.en;
        ctrl_o.fan_run = s.en & ~s.run[`HWM_RUN_PD] &
                         s.run[`HWM_RUN_FAN];
        ctrl_o.vt_run = s.en & ~s.run[`HWM_RUN_PD] &
                        s.run[`HWM_RUN_VT];
        ctrl_o.io_base = {s.bhi, s.blo};
        ctrl_o.monitor_irq_select = s.isel;
        ctrl_o.cpu_reading_smoothing_enable = s.cpu[`HWM_CPU_IIR];
        ctrl_o.vtt_select = s.cpu[`HWM_CPU_VTT +: 2];
        ctrl_o.cpu_temp_method_select = s.cpu[`HWM_CPU_METH +: 2];
    end

    // Checks below watch the design's own state and outputs.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A register write taken at this edge.
    sequence wr_take(logic [7:0] i);
        wr && idx == i;
    endsequence

    // A read answered one cycle after it was taken.
    sequence rd_answer(logic [7:0] i);
        (req && !wb_we_i && idx == i) ##1 wb_ack_o;
    endsequence

    bus_ack_a: assert property (
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Wishbone ack not a single cycle.");

    base_write_a: assert property (
        wr_take(`HWM_IDX_BHI) |=>
            ctrl_o.io_base[15:8] == $past(wb_dat_i[7:0]))
        else $error("Base high byte not stored.");

    isel_read_a: assert property (
        rd_answer(`HWM_IDX_ISEL) |-> wb_dat_o[31:4] == 28'h0)
        else $error("Channel select reserved bits not zero.");

    run_gate_a: assert property (
        ctrl_o.fan_run || ctrl_o.vt_run |->
            !s.run[`HWM_RUN_PD] && s.en)
        else $error("Monitoring runs while powered down.");

    flag_set_a: assert property (
        s.sy2[0] |=> s.flag)
        else $error("Intrusion did not set the flag.");

    flag_hold_a: assert property (
        s.flag && !(wr && idx == `HWM_IDX_CASE && wd[0]) |=> s.flag)
        else $error("Intrusion flag lost without a clear.");

    flag_clear_a: assert property (
        wr_take(`HWM_IDX_CASE) ##0 (wd[0] && !s.sy2[0]) |=> !s.flag)
        else $error("Write one did not clear the flag.");

    heat_low_a: assert property (
        s.mode[`HWM_MODE_HEAT +: 2] == 2'b00 |=>
            overheat_output_o == !$past(s.sy2[1]))
        else $error("Overheat low mode level wrong.");

    alert_high_a: assert property (
        s.mode[1:0] == 2'b01 |=> alert_output_o == $past(s.sy2[2]))
        else $error("Alert high mode level wrong.");

    beep_gate_a: assert property (
        !s.mode[`HWM_MODE_TONE] |=> !beep_o)
        else $error("Beep without tone enable.");

    pme_gate_a: assert property (
        pme_o |-> $past(s.mode[`HWM_MODE_PME]) && $past(s.flag))
        else $error("PME without enable and flag.");

    blink_rate_a: assert property (
        $changed(s.blink) |->
            $past(s.bcnt) == 24'(BLINK_HALF_CYC - 1))
        else $error("Blink toggled off its period.");

    tone_bound_a: assert property (
        s.tcnt <= 15'(T400_CYC - 1))
        else $error("Tone counter overran its half period.");

    irq_level_a: assert property (
        irq_o |-> $past(|(next_s.ists & next_s.ien)))
        else $error("Interrupt without enabled status.");

    // Write paths into the configuration levels, and the power down gate.
    en_write_a: assert property (
        wr_take(`HWM_IDX_EN) |=>
            ctrl_o.monitor_unit_enable == $past(wb_dat_i[0]))
        else $error("Unit enable not stored.");

    base_low_a: assert property (
        wr_take(`HWM_IDX_BLO) |=>
            ctrl_o.io_base[7:0] == $past(wb_dat_i[7:0]))
        else $error("Base low byte not stored.");

    isel_write_a: assert property (
        wr_take(`HWM_IDX_ISEL) |=>
            ctrl_o.monitor_irq_select == $past(wb_dat_i[3:0]))
        else $error("Channel select not stored.");

    pd_stop_a: assert property (
        ctrl_o.power_down |-> !ctrl_o.fan_run && !ctrl_o.vt_run)
        else $error("Monitoring runs in power down.");

    fan_start_a: assert property (
        wr_take(`HWM_IDX_RUN) ##0 (s.en && !wd[`HWM_RUN_PD]) |=>
            ctrl_o.fan_run == $past(wd[`HWM_RUN_FAN]))
        else $error("Fan start bit not followed.");

    vt_start_a: assert property (
        wr_take(`HWM_IDX_RUN) ##0 (s.en && !wd[`HWM_RUN_PD]) |=>
            ctrl_o.vt_run == $past(wd[`HWM_RUN_VT]))
        else $error("Sensing start bit not followed.");

    // Intrusion reporting paths.
    beep_on_a: assert property (
        s.flag && s.mode[`HWM_MODE_TONE] && s.tone |=> beep_o)
        else $error("Enabled intrusion tone missing.");

    pme_on_a: assert property (
        s.flag && s.mode[`HWM_MODE_PME] |=> pme_o)
        else $error("Enabled intrusion PME missing.");

    case_read_a: assert property (
        rd_answer(`HWM_IDX_CASE) |-> wb_dat_o[31:1] == 31'h0)
        else $error("Intrusion register upper bits not zero.");

    // Pin modes not covered above.
    heat_high_a: assert property (
        s.mode[`HWM_MODE_HEAT +: 2] == 2'b01 |=>
            overheat_output_o == $past(s.sy2[1]))
        else $error("Overheat high mode level wrong.");

    heat_blink_a: assert property (
        s.mode[`HWM_MODE_HEAT +: 2] == 2'b10 |=>
            overheat_output_o == ($past(s.sy2[1]) && $past(s.blink)))
        else $error("Overheat blink mode wrong.");

    alert_low_a: assert property (
        s.mode[`HWM_MODE_ALERT +: 2] == 2'b00 |=>
            alert_output_o == !$past(s.sy2[2]))
        else $error("Alert low mode level wrong.");

    alert_tone_a: assert property (
        s.mode[`HWM_MODE_ALERT +: 2] == 2'b11 |=>
            alert_output_o == ($past(s.sy2[2]) && $past(s.tone)))
        else $error("Alert tone mode wrong.");

    // CPU temperature configuration writes.
    smooth_write_a: assert property (
        wr_take(`HWM_IDX_CPU) |=> ctrl_o.cpu_reading_smoothing_enable ==
            $past(wb_dat_i[`HWM_CPU_IIR]))
        else $error("Smoothing enable not stored.");

    vtt_write_a: assert property (
        wr_take(`HWM_IDX_CPU) |=>
            ctrl_o.vtt_select == $past(wb_dat_i[`HWM_CPU_VTT +: 2]))
        else $error("Interface voltage select not stored.");

    method_write_a: assert property (
        wr_take(`HWM_IDX_CPU) |=> ctrl_o.cpu_temp_method_select ==
            $past(wb_dat_i[`HWM_CPU_METH +: 2]))
        else $error("Measurement method not stored.");

endmodule : hwmcr_regs

// [test/hwmcr_host.sv]
// Wishbone master model standing in for the host software.
`timescale 1ns/1ps
module hwmcr_host (
    // Clock.
    input wire logic clk_i,
    // Wishbone master side.
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [9:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    int stuck = 0;

    // Bus idle at time zero.
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 10'h000;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One classic cycle, held until ack is sampled high at an edge or 64 edges pass.
    task automatic xfer(input logic w, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [7:0] rd);
        int k;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'h1;
        dat_o <= {24'h0, wd};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_i !== 1'b1 && k < 64);
        rd = dat_i[7:0];
        if (k >= 64) stuck++;
        // Control lines drop and address and data are inverted so stale values are never trusted.
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : hwmcr_host

// [test/hwmcr_regs_tb.sv]
// Self-checking bench for the monitor configuration registers.
`timescale 1ns/1ps
module hwmcr_regs_tb import hwmcr_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic intr = 1'b0;
    logic heat_ev = 1'b0;
    logic alr_ev = 1'b0;
    logic heat_o, alr_o, beep_o, pme_o, irq_o;
    hwmcr_ctrl_t ctrl;
    int fails = 0;
    int n_checks = 0;

    // Short timebase counts keep blink and tone within a short run.
    hwmcr_regs #(.BLINK_HALF_CYC(20), .T800_CYC(4), .T400_CYC(8))
    u_hwmcr_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .intrusion_i(intr), .overheat_event_i(heat_ev),
        .alert_event_i(alr_ev), .overheat_output_o(heat_o),
        .alert_output_o(alr_o), .beep_o(beep_o), .pme_o(pme_o),
        .irq_o(irq_o), .ctrl_o(ctrl));

    hwmcr_host u_hwmcr_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
        .dat_i(rdat), .ack_i(ack));

    // Free-running 20 MHz clock.
    always #25 clk_i = ~clk_i;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [7:0] r;
        u_hwmcr_host.xfer(1'b1, idx, d, r);
    endtask : wr

    task automatic rdchk(logic [7:0] idx, logic [7:0] e);
        logic [7:0] r;
        u_hwmcr_host.xfer(1'b0, idx, 8'h00, r);
        chk($sformatf("reg %h", idx), {24'h0, e}, {24'h0, r});
    endtask : rdchk

    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Counts changes of alert (0), overheat (1) or beep (2) output.
    task automatic count_edges(input int which, output int t);
        logic last, cur;
        t = 0;
        last = which == 0 ? alr_o : which == 1 ? heat_o : beep_o;
        repeat (60) begin
            @(posedge clk_i);
            cur = which == 0 ? alr_o : which == 1 ? heat_o : beep_o;
            if (cur !== last) t++;
            last = cur;
        end
    endtask : count_edges

    // A hung bus ends the run when the scenario that hit it finishes.
    task automatic done(string name);
        $display("test %s finished", name);
        if (u_hwmcr_host.stuck != 0) begin
            fails++;
            wrap_up();
        end
    endtask : done

    task automatic t_reset();
        logic [7:0] ix [8] = '{8'h01, 8'h02, 8'h03, 8'h0a, 8'h30, 8'h60,
                               8'h61, 8'h70};
        logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02,
                               8'h95, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rdchk(ix[i], rv[i]);
        end
        chk("io_base", 32'h0295, {16'h0, ctrl.io_base});
        chk("pins", 32'h3, {30'h0, heat_o, alr_o});
        done("reset");
    endtask : t_reset

    task automatic t_fields();
        wr(8'h60, 8'ha5);
        wr(8'h61, 8'h5a);
        rdchk(8'h61, 8'h5a);
        chk("io_base", 32'ha55a, {16'h0, ctrl.io_base});
        wr(8'h70, 8'hff);
        rdchk(8'h70, 8'h0f);
        chk("irq sel", 32'hf, {28'h0, ctrl.monitor_irq_select});
        wr(8'h01, 8'h07);
        chk("pd", 32'h4, {29'h0, ctrl.power_down, ctrl.fan_run,
            ctrl.vt_run});
        wr(8'h01, 8'h02);
        chk("run", 32'h2, {30'h0, ctrl.fan_run, ctrl.vt_run});
        wr(8'h01, 8'h01);
        chk("run", 32'h1, {30'h0, ctrl.fan_run, ctrl.vt_run});
        wr(8'h30, 8'h00);
        rdchk(8'h30, 8'h00);
        chk("off", 32'h4, {28'h0, ctrl.monitor_unit_enable,
            ctrl.power_down, ctrl.fan_run, ctrl.vt_run});
        wr(8'h30, 8'h01);
        wr(8'h0a, 8'h2e);
        rdchk(8'h0a, 8'h2e);
        chk("smooth", 32'h1,
            {31'h0, ctrl.cpu_reading_smoothing_enable});
        for (int m = 0; m < 4; m++) begin
            wr(8'h0a, {4'h0, 2'(m), 2'(m)});
            chk("cpu sel", 32'(m * 5), {28'h0, ctrl.vtt_select,
                ctrl.cpu_temp_method_select});
        end
        wr(8'h05, 8'hff);
        rdchk(8'h05, 8'h00);
        done("fields");
    endtask : t_fields

    task automatic t_intrusion();
        int t;
        intr <= 1'b1;
        tick(5);
        rdchk(8'h03, 8'h01);
        chk("pme beep off", 32'h0, {30'h0, pme_o, beep_o});
        wr(8'h02, 8'h44);
        tick(2);
        chk("pme on", 32'h1, {31'h0, pme_o});
        count_edges(2, t);
        chk("beep tone", 32'h1, {31'h0, t > 0});
        wr(8'h03, 8'h01);
        rdchk(8'h03, 8'h01);
        intr <= 1'b0;
        tick(5);
        rdchk(8'h03, 8'h01);
        // Software clears only once the case is closed again.
        wr(8'h03, 8'h01);
        tick(2);
        rdchk(8'h03, 8'h00);
        chk("pme beep idle", 32'h0, {30'h0, pme_o, beep_o});
        wr(8'h02, 8'h00);
        done("intrusion");
    endtask : t_intrusion

    task automatic t_irq();
        wr(8'h81, 8'h07);
        wr(8'h82, 8'h01);
        rdchk(8'h82, 8'h01);
        tick(2);
        chk("irq clear", 32'h0, {31'h0, irq_o});
        intr <= 1'b1;
        tick(6);
        chk("irq set", 32'h1, {31'h0, irq_o});
        rdchk(8'h80, 8'h01);
        wr(8'h82, 8'h00);
        tick(2);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(8'h82, 8'h01);
        tick(2);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        intr <= 1'b0;
        tick(5);
        wr(8'h81, 8'h01);
        tick(2);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rdchk(8'h80, 8'h00);
        rdchk(8'h81, 8'h00);
        wr(8'h03, 8'h01);
        done("irq");
    endtask : t_irq

    task automatic t_modes();
        int t;
        for (int e = 1; e >= 0; e--) begin
            heat_ev <= e[0];
            alr_ev <= e[0];
            for (int m = 0; m < 4; m++) begin
                wr(8'h02, {2'b00, 2'(m), 2'b00, 2'(m)});
                tick(5);
                if (m < 2 || e == 0) begin
                    chk("pins", (m < 2 && (m == 1) == (e == 1)) ? 32'h3 :
                        32'h0, {30'h0, heat_o, alr_o});
                end else begin
                    count_edges(0, t);
                    chk("alert wave", 32'h1, {31'h0, t > 0});
                    count_edges(1, t);
                    chk("heat wave", 32'h1, {31'h0, t > 0});
                end
            end
        end
        done("modes");
    endtask : t_modes

    // Reset for 16 cycles, then each scenario in turn.
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_intrusion();
        t_irq();
        t_modes();
        wrap_up();
    end
endmodule : hwmcr_regs_tb
